//--- pkg/keypad_pin_interrupt_params.svh
// offsets, field positions and reset values of the pin interrupt unit
// assumes an 8-bit register port whose high nibble picks the instance
`ifndef KEYPAD_PIN_INTERRUPT_PARAMS_SVH
`define KEYPAD_PIN_INTERRUPT_PARAMS_SVH

`define ADDR_W 8
`define DATA_W 8
`define PIN_COUNT 8
`define INST_W 4

// register offsets inside one instance
`define OFS_STATUS_CTRL 4'h0
`define OFS_ENABLE 4'h1
`define OFS_POLARITY 4'h2
`define OFS_EVT_STATUS 4'h3
`define OFS_EVT_MASK 4'h4

// status-and-control field positions
`define BIT_DETECT_MODE 0
`define BIT_IRQ_ENABLE 1
`define BIT_FLAG_ACK 2
`define BIT_IRQ_FLAG 3

// reset values
`define RST_STATUS_CTRL 8'h00
`define RST_ENABLE 8'h00
`define RST_POLARITY 8'h00
`define RST_EVT_MASK 8'h00
`define UNMAPPED_READ 8'h00

`endif

//--- pkg/keypad_pin_interrupt_pkg.sv
// types shared by the pin interrupt unit and its leaf modules
// assumes the params header for widths
`include "keypad_pin_interrupt_params.svh"

package keypad_pin_interrupt_pkg;

  // register port request, one per cycle
  typedef struct packed {
    logic [`ADDR_W-1:0] addr;
    logic [`DATA_W-1:0] wdata;
    logic wr;
    logic rd;
  } reg_req_t;

  // status-and-control layout as software sees it
  typedef struct packed {
    logic [3:0] reserved;
    logic irq_flag;
    logic flag_ack;
    logic irq_enable_bit;
    logic detect_mode;
  } status_ctrl_t;

  typedef struct packed {
    logic prev_asserted;
  } pin_cell_state_t;

  typedef struct packed {
    logic irq_flag;
    logic irq_enable_bit;
    logic detect_mode;
    logic armed;
    logic [`PIN_COUNT-1:0] pin_enable_field;
    logic [`PIN_COUNT-1:0] polarity_select;
    logic [`DATA_W-1:0] rdata;
  } top_state_t;

endpackage

//--- rtl/pin_edge_cell.sv
// one watched pin: samples its asserted level and reports edge and level
// assumes the pin is already synchronous to sys_clk
`timescale 1ns/1ps

module pin_edge_cell
  import keypad_pin_interrupt_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic irq_input_pin,
  input wire logic pin_enable_bit,
  input wire logic polarity_select,
  output logic edge_hit,
  output logic level_hit
);

  pin_cell_state_t st_q;
  pin_cell_state_t st_d;
  logic asserted;

  always_comb begin
    st_d = st_q;
    // polarity 1 asserts high, 0 asserts low
    asserted = (irq_input_pin == polarity_select);
    st_d.prev_asserted = asserted;
  end

  // deasserted last cycle, asserted now
  assign edge_hit = pin_enable_bit & asserted & ~st_q.prev_asserted;
  // no clock in this path, so it still works with the bus clock stopped
  assign level_hit = pin_enable_bit & asserted;

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

endmodule

//--- rtl/sticky_events.sv
// sticky event bits, write-one-to-clear, with a mask and one level irq
// assumes set and clear strobes are one cycle each
`timescale 1ns/1ps

module sticky_events #(
  parameter int WIDTH = 8
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [WIDTH-1:0] event_set,
  input wire logic clear_wr,
  input wire logic mask_wr,
  input wire logic [WIDTH-1:0] wdata,
  output logic [WIDTH-1:0] status,
  output logic [WIDTH-1:0] mask,
  output logic irq
);

  typedef struct packed {
    logic [WIDTH-1:0] status;
    logic [WIDTH-1:0] mask;
  } evt_state_t;

  evt_state_t st_q;
  evt_state_t st_d;

  always_comb begin
    st_d = st_q;
    if (clear_wr) begin
      st_d.status = st_q.status & ~wdata;
    end
    // a new event beats a clear in the same cycle
    st_d.status = st_d.status | event_set;
    if (mask_wr) begin
      st_d.mask = wdata;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  assign status = st_q.status;
  assign mask = st_q.mask;
  assign irq = |(st_q.status & st_q.mask);

endmodule

//--- rtl/keypad_pin_interrupt.sv
// keypad pin interrupt unit: eight watched pins, one shared request,
// wake-up from wait and stop3, per-pin event log with its own irq
// assumes synchronous pins, a one-cycle register port, sync reset
//
// Behaviour
// - up to eight pins, each with an enable; disabled pins never count
// - each pin: falling, rising, falling plus low, rising plus high
// - all pins share one request, gated by one software enable
// - unit keeps running in wait; enabled event wakes the cpu
// - stop3 detection works without the bus clock and wakes the cpu
// - in background debug the unit works exactly as in run mode
// - five 8-bit registers: status-control, pin enable, polarity, event status, event mask
// - several instances possible, each selected by its own index
// - edge is deasserted in one cycle, asserted in the next
// - event sets a read-only flag; writing ack one clears it
// - in level mode ack leaves flag set while a pin stays asserted
// - status bits: 3 flag, 2 ack, 1 enable, 0 mode; 7..4 read zero
`timescale 1ns/1ps
`include "keypad_pin_interrupt_params.svh"

module keypad_pin_interrupt
  import keypad_pin_interrupt_pkg::*;
#(
  parameter logic [`INST_W-1:0] INST_INDEX = 4'h0,
  parameter int PINS = `PIN_COUNT
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire reg_req_t bus_req,
  output logic [`DATA_W-1:0] rdata,
  input wire logic [PINS-1:0] irq_input_pin,
  input wire logic stop3_mode,
  output logic irq_req,
  output logic wake_req,
  output logic evt_irq
);

  top_state_t st_q;
  top_state_t st_d;

  logic [PINS-1:0] edge_hit;
  logic [PINS-1:0] level_hit;
  logic [PINS-1:0] pin_event;
  logic [PINS-1:0] evt_status;
  logic [PINS-1:0] evt_mask;
  logic [3:0] offset;
  logic selected;
  logic wr_sc;
  logic wr_pe;
  logic wr_es;
  logic wr_evt_status;
  logic wr_evt_mask;
  logic any_edge;
  logic any_level;
  logic flag_set;
  logic ack;
  status_ctrl_t sc_view;

  // one cell per pin; all share the same detection code
  genvar gi;
  generate
    for (gi = 0; gi < PINS; gi++) begin : g_pin
      pin_edge_cell u_cell (
        .sys_clk(sys_clk),
        .rst(rst),
        .irq_input_pin(irq_input_pin[gi]),
        .pin_enable_bit(st_q.pin_enable_field[gi]),
        .polarity_select(st_q.polarity_select[gi]),
        .edge_hit(edge_hit[gi]),
        .level_hit(level_hit[gi])
      );
    end
  endgenerate

  // instance picked by the high address nibble
  assign offset = bus_req.addr[3:0];
  assign selected = (bus_req.addr[`ADDR_W-1:4] == INST_INDEX);

  always_comb begin
    wr_sc = 1'b0;
    wr_pe = 1'b0;
    wr_es = 1'b0;
    wr_evt_status = 1'b0;
    wr_evt_mask = 1'b0;
    if (!(bus_req.wr && selected)) begin
      wr_sc = 1'b0;
    end else if (offset == `OFS_STATUS_CTRL) begin
      wr_sc = 1'b1;
    end else if (offset == `OFS_ENABLE) begin
      wr_pe = 1'b1;
    end else if (offset == `OFS_POLARITY) begin
      wr_es = 1'b1;
    end else if (offset == `OFS_EVT_STATUS) begin
      wr_evt_status = 1'b1;
    end else if (offset == `OFS_EVT_MASK) begin
      wr_evt_mask = 1'b1;
    end
  end

  assign ack = wr_sc & bus_req.wdata[`BIT_FLAG_ACK];
  assign any_level = |level_hit;

  // a new edge counts only after every enabled pin went deasserted,
  // so one held key cannot retrigger the flag in edge mode
  assign any_edge = st_q.armed & (|edge_hit);
  // pins keep being watched in every cpu mode, debug included
  assign pin_event = (st_q.armed ? edge_hit : '0)
                   | (st_q.detect_mode ? level_hit : '0);
  assign flag_set = |pin_event;

  always_comb begin
    sc_view = '0;
    sc_view.irq_flag = st_q.irq_flag;
    sc_view.flag_ack = 1'b0;
    sc_view.irq_enable_bit = st_q.irq_enable_bit;
    sc_view.detect_mode = st_q.detect_mode;
  end

  always_comb begin
    st_d = st_q;
    if (any_edge) begin
      st_d.armed = 1'b0;
    end else if (!any_level) begin
      st_d.armed = 1'b1;
    end
    // flag has no write path; only ack clears it
    if (flag_set) begin
      st_d.irq_flag = 1'b1;
    end else if (ack) begin
      // a still-asserted pin in level mode keeps it up
      st_d.irq_flag = st_q.detect_mode & any_level;
    end
    if (wr_sc) begin
      st_d.irq_enable_bit = bus_req.wdata[`BIT_IRQ_ENABLE];
      st_d.detect_mode = bus_req.wdata[`BIT_DETECT_MODE];
    end
    if (wr_pe) begin
      st_d.pin_enable_field = bus_req.wdata[PINS-1:0];
    end
    if (wr_es) begin
      st_d.polarity_select = bus_req.wdata[PINS-1:0];
    end
    // read data stand only in the cycle after the strobe
    st_d.rdata = `UNMAPPED_READ;
    if (!(bus_req.rd && selected)) begin
      st_d.rdata = `UNMAPPED_READ;
    end else if (offset == `OFS_STATUS_CTRL) begin
      st_d.rdata = sc_view;
    end else if (offset == `OFS_ENABLE) begin
      st_d.rdata = st_q.pin_enable_field;
    end else if (offset == `OFS_POLARITY) begin
      st_d.rdata = st_q.polarity_select;
    end else if (offset == `OFS_EVT_STATUS) begin
      st_d.rdata = evt_status;
    end else if (offset == `OFS_EVT_MASK) begin
      st_d.rdata = evt_mask;
    end
  end

  always_ff @(posedge sys_clk) begin
    if (rst) begin
      st_q <= '0;
    end else begin
      st_q <= st_d;
    end
  end

  // per-pin log of which pin fired, for software that must tell them apart
  sticky_events #(
    .WIDTH(PINS)
  ) u_events (
    .sys_clk(sys_clk),
    .rst(rst),
    .event_set(pin_event),
    .clear_wr(wr_evt_status),
    .mask_wr(wr_evt_mask),
    .wdata(bus_req.wdata[PINS-1:0]),
    .status(evt_status),
    .mask(evt_mask),
    .irq(evt_irq)
  );

  assign rdata = st_q.rdata;
  // one shared request for all pins
  assign irq_req = st_q.irq_flag & st_q.irq_enable_bit;
  // wait: the clocked request wakes the cpu
  // stop3: raw pin level, no clock needed; enable must be set first
  assign wake_req = irq_req
                  | (stop3_mode & st_q.irq_enable_bit & any_level);

endmodule

//--- bench/key_switches.sv
// switch bank on the far side of the watched pins
// assumes the bench moves idle_lvl and press right after a clock edge
`timescale 1ns/1ps

module key_switches (
  input wire logic [7:0] idle_lvl,
  input wire logic [7:0] press,
  output logic [7:0] pins
);
  // pressed switch drives the opposite of its resting level
  assign pins = idle_lvl ^ press;
endmodule

//--- bench/keypad_pin_interrupt_asserts.sv
// port-level checks for the pin interrupt unit
// assumes binding to the top module, one clock, sync reset
`timescale 1ns/1ps

module keypad_pin_interrupt_asserts
  import keypad_pin_interrupt_pkg::*;
#(
  parameter logic [3:0] INST_INDEX = 4'h0,
  parameter int PINS = 8
) (
  input wire logic sys_clk,
  input wire logic rst,
  input wire reg_req_t bus_req,
  input wire logic [7:0] rdata,
  input wire logic [PINS-1:0] irq_input_pin,
  input wire logic stop3_mode,
  input wire logic irq_req,
  input wire logic wake_req,
  input wire logic evt_irq
);
  localparam logic [7:0] A_SC = {INST_INDEX, 4'h0};
  localparam logic [7:0] A_PE = {INST_INDEX, 4'h1};
  default clocking cb @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_wr(a);
    bus_req.wr && bus_req.addr == a;
  endsequence
  sequence s_rd(a);
    bus_req.rd && bus_req.addr == a;
  endsequence
  sequence s_pe_trip;
    s_wr(A_PE) ##1 !bus_req.wr ##1 s_rd(A_PE);
  endsequence

  property p_rd_idle;
    !$past(bus_req.rd) |-> rdata == 8'h00;
  endproperty
  property p_sc_fmt;
    s_rd(A_SC) |=> rdata[7:4] == 4'h0 && !rdata[2];
  endproperty
  property p_sc_flag;
    s_rd(A_SC) |=> (rdata[3] && rdata[1]) == $past(irq_req);
  endproperty
  property p_foreign;
    bus_req.rd && bus_req.addr[7:4] != INST_INDEX |=> rdata == 8'h00;
  endproperty
  property p_hole;
    bus_req.rd && bus_req.addr[3:0] > 4'h4 |=> rdata == 8'h00;
  endproperty
  property p_pe_back;
    s_pe_trip |=> rdata == $past(bus_req.wdata, 3);
  endproperty
  property p_irq_wake;
    irq_req |-> wake_req;
  endproperty
  property p_no_stop;
    !stop3_mode |-> wake_req == irq_req;
  endproperty
  property p_en_off;
    s_wr(A_SC) and !bus_req.wdata[1] |=> !irq_req;
  endproperty
  property p_reset;
    $fell(rst) |-> !irq_req && !evt_irq && rdata == 8'h00;
  endproperty

  a_rd_idle: assert property (p_rd_idle)
    else $error("stray read data");
  a_sc_fmt: assert property (p_sc_fmt)
    else $error("status bits");
  a_sc_flag: assert property (p_sc_flag)
    else $error("flag read");
  a_foreign: assert property (p_foreign)
    else $error("other index");
  a_hole: assert property (p_hole)
    else $error("unmapped read");
  a_pe_back: assert property (p_pe_back)
    else $error("enable reg");
  a_irq_wake: assert property (p_irq_wake)
    else $error("no wake");
  a_no_stop: assert property (p_no_stop)
    else $error("wake in run");
  a_en_off: assert property (p_en_off)
    else $error("masked irq");
  a_reset: assert property (p_reset)
    else $error("reset state");
endmodule

bind keypad_pin_interrupt keypad_pin_interrupt_asserts #(
  .INST_INDEX(INST_INDEX), .PINS(PINS)) chk_i (
  .sys_clk(sys_clk), .rst(rst), .bus_req(bus_req), .rdata(rdata),
  .irq_input_pin(irq_input_pin), .stop3_mode(stop3_mode),
  .irq_req(irq_req), .wake_req(wake_req), .evt_irq(evt_irq));

//--- bench/keypad_pin_interrupt_test.sv
// self-checking bench for the pin interrupt unit
// assumes the switch model on the pins and the bound checker
`timescale 1ns/1ps

module keypad_pin_interrupt_test
  import keypad_pin_interrupt_pkg::*;
;
  logic sys_clk = 1'b0;
  logic rst = 1'b1;
  logic stop3_mode = 1'b0;
  reg_req_t bus_req = '0;
  logic [7:0] idle_lvl = 8'hFF;
  logic [7:0] press = 8'h00;
  logic [7:0] pins;
  logic [7:0] rdata;
  logic irq_req, wake_req, evt_irq;
  int n_fail = 0;
  int checks_done = 0;

  key_switches sw (.idle_lvl(idle_lvl), .press(press), .pins(pins));
  keypad_pin_interrupt DUT (.sys_clk(sys_clk), .rst(rst),
    .bus_req(bus_req), .rdata(rdata), .irq_input_pin(pins),
    .stop3_mode(stop3_mode), .irq_req(irq_req), .wake_req(wake_req),
    .evt_irq(evt_irq));

  initial forever #5 sys_clk = ~sys_clk;

  task automatic chk(input string nm, input logic [7:0] seen, exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("[FAIL] %s expected %h seen %h", nm, exp, seen);
    end
  endtask
  task automatic step(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic wr(input logic [7:0] a, d);
    @(posedge sys_clk);
    bus_req <= '{a, d, 1'b1, 1'b0};
    @(posedge sys_clk);
    bus_req <= '0;
    #1;
  endtask
  task automatic rd(input string nm, input logic [7:0] a, exp);
    @(posedge sys_clk);
    bus_req <= '{a, 8'h00, 1'b0, 1'b1};
    @(posedge sys_clk);
    bus_req <= '0;
    #1;
    chk(nm, rdata, exp);
  endtask
  task automatic pin(input logic [7:0] p);
    @(posedge sys_clk);
    press <= p;
    step(3);
  endtask

  task automatic t_regs;
    rd("sc", 8'h00, 8'h00);
    rd("pe", 8'h01, 8'h00);
    rd("es", 8'h02, 8'h00);
    rd("other", 8'h10, 8'h00);
    wr(8'h01, 8'hA5);
    rd("pe", 8'h01, 8'hA5);
    wr(8'h02, 8'h5A);
    rd("es", 8'h02, 8'h5A);
    wr(8'h00, 8'hFF);
    rd("sc", 8'h00, 8'h03);
    rd("hole", 8'h05, 8'h00);
    wr(8'h00, 8'h00);
    wr(8'h01, 8'h00);
    $display("regs done");
  endtask

  task automatic t_edge(input logic pol);
    // resting level set before the pin is enabled, so no false edge
    @(posedge sys_clk);
    idle_lvl <= pol ? 8'h00 : 8'hFF;
    wr(8'h02, {7'h00, pol});
    wr(8'h01, 8'h01);
    wr(8'h00, 8'h02);
    pin(8'h02);
    chk("disabled", irq_req, 1'b0);
    pin(8'h00);
    pin(8'h01);
    chk("edge", irq_req, 1'b1);
    wr(8'h00, 8'h08);
    chk("masked", irq_req, 1'b0);
    rd("flag", 8'h00, 8'h08);
    wr(8'h00, 8'h02);
    chk("unmasked", irq_req, 1'b1);
    pin(8'h00);
    wr(8'h00, 8'h06);
    chk("ack", irq_req, 1'b0);
    wr(8'h01, 8'h00);
    $display("edge done");
  endtask

  task automatic t_level;
    @(posedge sys_clk);
    idle_lvl <= 8'hFF;
    // back to falling/low, else a high resting pin is already asserted
    wr(8'h02, 8'h00);
    wr(8'h01, 8'h01);
    wr(8'h00, 8'h03);
    pin(8'h01);
    wr(8'h00, 8'h07);
    chk("held", irq_req, 1'b1);
    pin(8'h00);
    wr(8'h00, 8'h07);
    chk("freed", irq_req, 1'b0);
    wr(8'h00, 8'h02); // enable set before stop3
    stop3_mode <= 1'b1;
    @(posedge sys_clk);
    press <= 8'h01;
    #1;
    chk("wake", wake_req, 1'b1);
    step(3);
    chk("irq", irq_req, 1'b1);
    @(posedge sys_clk);
    press <= 8'h00;
    stop3_mode <= 1'b0;
    wr(8'h00, 8'h06);
    $display("level done");
  endtask

  task automatic t_evt;
    wr(8'h04, 8'h01);
    chk("evt on", evt_irq, 1'b1);
    wr(8'h03, 8'h01);
    chk("evt off", evt_irq, 1'b0);
    rd("evt", 8'h03, 8'h00);
    $display("evt done");
  endtask

  task automatic end_sim;
    $display("checks %0d mismatches %0d", checks_done, n_fail);
    if (n_fail == 0 && checks_done > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask

  initial begin
    repeat (12) @(posedge sys_clk);
    rst <= 1'b0;
    t_regs();
    t_edge(1'b0);
    t_edge(1'b1);
    t_level();
    t_evt();
    end_sim();
  end

  initial begin
    #200000;
    n_fail++;
    end_sim();
  end
endmodule
